//--- verilog/bst_tap.sv
// boundary-scan test access port: tap controller, instruction, bypass and boundary registers
// assumes tck comes from the external tester and is unrelated to clk_sys;
// pad pull-ups on the test inputs are enabled by pullUpEn and resolved outside
`timescale 1ns/1ps
`default_nettype none
module bst_tap #(
	parameter int BSR_LEN = bst_pkg::BSR_LEN_DEF
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdoOe,
	output logic pullUpEn,
	input wire logic [BSR_LEN-1:0] pinIn,
	input wire logic [BSR_LEN-1:0] coreOut,
	output logic [BSR_LEN-1:0] pinOut
);
	// ---------------- tck domain ----------------
	logic rstTckMeta;
	logic rstTck;
	bst_pkg::bst_tap_state_t state;
	bst_pkg::bst_tap_state_t next_state;
	logic [bst_pkg::IR_LEN-1:0] ir;
	logic [bst_pkg::IR_LEN-1:0] irShift;
	logic bypassReg;
	logic [BSR_LEN-1:0] bsrShift;
	logic [BSR_LEN-1:0] updReg;
	logic updTog;
	logic extestTck;
	bst_pkg::bst_tdo_t tdoQ;
	bst_pkg::bst_tdo_t next_tdo;
	logic [BSR_LEN-1:0] snapTck;
	logic reqMeta;
	logic reqSync;
	logic ackTck;
	// ---------------- clk_sys domain ----------------
	logic [BSR_LEN-1:0] pinMeta;
	logic [BSR_LEN-1:0] pinSync;
	logic [BSR_LEN-1:0] xferWord;
	logic reqSys;
	logic ackMeta;
	logic ackSys;
	logic updMeta;
	logic updSync;
	logic updSeen;
	logic [BSR_LEN-1:0] updSys;
	logic extestMeta;
	logic extestSys;
	logic bufInReady;
	logic bufOutValid;
	logic [BSR_LEN-1:0] bufOutData;

	// tap state transitions on rising tck
	always_comb begin
		case (state)
			bst_pkg::TLR: next_state = tms ? bst_pkg::TLR : bst_pkg::RTI;
			bst_pkg::RTI: next_state = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
			bst_pkg::SEL_DR: next_state = tms ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
			bst_pkg::CAP_DR: next_state = tms ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
			bst_pkg::SH_DR: next_state = tms ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
			bst_pkg::EX1_DR: next_state = tms ? bst_pkg::UP_DR : bst_pkg::PA_DR;
			bst_pkg::PA_DR: next_state = tms ? bst_pkg::EX2_DR : bst_pkg::PA_DR;
			bst_pkg::EX2_DR: next_state = tms ? bst_pkg::UP_DR : bst_pkg::SH_DR;
			bst_pkg::UP_DR: next_state = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
			bst_pkg::SEL_IR: next_state = tms ? bst_pkg::TLR : bst_pkg::CAP_IR;
			bst_pkg::CAP_IR: next_state = tms ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
			bst_pkg::SH_IR: next_state = tms ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
			bst_pkg::EX1_IR: next_state = tms ? bst_pkg::UP_IR : bst_pkg::PA_IR;
			bst_pkg::PA_IR: next_state = tms ? bst_pkg::EX2_IR : bst_pkg::PA_IR;
			bst_pkg::EX2_IR: next_state = tms ? bst_pkg::UP_IR : bst_pkg::SH_IR;
			bst_pkg::UP_IR: next_state = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
			default: next_state = bst_pkg::TLR;
		endcase
	end

	// instruction decode; anything not listed falls through to bypass
	wire isExtest = (ir == bst_pkg::OP_EXTEST);
	wire isSample = (ir == bst_pkg::OP_SAMPLE);
	wire bsrSel = isExtest || isSample;
	wire inCapDr = (state == bst_pkg::CAP_DR);
	wire inShDr = (state == bst_pkg::SH_DR);
	wire inUpDr = (state == bst_pkg::UP_DR);
	wire inShIr = (state == bst_pkg::SH_IR);
	wire reqPending = (reqSync != ackTck);
	wire drOut = bsrSel ? bsrShift[0] : bypassReg;

	// tck has no reset pin of its own, so the system reset is brought over
	always_ff @(posedge tck) begin
		rstTckMeta <= rst;
		rstTck <= rstTckMeta;
	end

	always_ff @(posedge tck) begin
		if (rstTck) begin
			state <= bst_pkg::TLR;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge tck) begin
		if (rstTck || state == bst_pkg::TLR) begin
			ir <= bst_pkg::OP_BYPASS;
			irShift <= bst_pkg::IR_CAPT;
		end else if (state == bst_pkg::CAP_IR) begin
			irShift <= bst_pkg::IR_CAPT;
		end else if (inShIr) begin
			irShift <= {tdi, irShift[bst_pkg::IR_LEN-1:1]};
		end else if (state == bst_pkg::UP_IR) begin
			ir <= irShift;
		end
	end

	always_ff @(posedge tck) begin
		if (rstTck) begin
			bypassReg <= 1'b0;
		end else if (inCapDr) begin
			bypassReg <= 1'b0;
		end else if (inShDr) begin
			bypassReg <= tdi;
		end
	end

	// capture loads the latest pin snapshot for both sample and extest
	always_ff @(posedge tck) begin
		if (rstTck) begin
			bsrShift <= '0;
		end else if (inCapDr && bsrSel) begin
			bsrShift <= snapTck;
		end else if (inShDr && bsrSel) begin
			bsrShift <= {tdi, bsrShift[BSR_LEN-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (rstTck) begin
			updReg <= '0;
			updTog <= 1'b0;
		end else if (inUpDr && bsrSel) begin
			updReg <= bsrShift;
			updTog <= ~updTog;
		end
	end

	always_ff @(posedge tck) begin
		if (rstTck) begin
			extestTck <= 1'b0;
		end else begin
			extestTck <= isExtest;
		end
	end

	// snapshot words arrive by a req/ack toggle; xferWord is held until ack returns
	always_ff @(posedge tck) begin
		if (rstTck) begin
			reqMeta <= 1'b0;
			reqSync <= 1'b0;
			ackTck <= 1'b0;
			snapTck <= '0;
		end else begin
			reqMeta <= reqSys;
			reqSync <= reqMeta;
			if (reqPending) begin
				snapTck <= xferWord;
				ackTck <= reqSync;
			end
		end
	end

	assign next_tdo = '{data: (inShIr ? irShift[0] : drOut), oe: (inShIr || inShDr)};

	always_ff @(negedge tck) begin
		if (rstTck) begin
			tdoQ <= '0;
		end else begin
			tdoQ <= next_tdo;
		end
	end

	assign tdo = tdoQ.data;
	assign tdoOe = tdoQ.oe;

	// ---------------- clk_sys side ----------------
	always_ff @(posedge clk_sys) begin
		pinMeta <= pinIn;
		pinSync <= pinMeta;
	end

	wire reqIdle = (reqSys == ackSys);

	// when the crossing is busy the buffer fills and new pin samples are dropped until it drains
	// limitation: with tck stopped the queued words age, so tck has to run for a few
	// handshakes before capture-dr to see the current pins
	bst_buf #(
		.WIDTH(BSR_LEN),
		.DEPTH(bst_pkg::BUF_DEPTH_DEF)
	) u_snapBuf (
		.clk(clk_sys),
		.rst(rst),
		.inValid(1'b1),
		.inReady(bufInReady),
		.inData(pinSync),
		.outValid(bufOutValid),
		.outReady(reqIdle),
		.outData(bufOutData)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reqSys <= 1'b0;
			xferWord <= '0;
			ackMeta <= 1'b0;
			ackSys <= 1'b0;
		end else begin
			ackMeta <= ackTck;
			ackSys <= ackMeta;
			if (bufOutValid && reqIdle) begin
				xferWord <= bufOutData;
				reqSys <= ~reqSys;
			end
		end
	end

	// updReg only moves at update-dr, several tck apart, so it is stable by the time
	// the toggle has passed the synchroniser
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			updMeta <= 1'b0;
			updSync <= 1'b0;
			updSeen <= 1'b0;
			updSys <= '0;
			extestMeta <= 1'b0;
			extestSys <= 1'b0;
		end else begin
			updMeta <= updTog;
			updSync <= updMeta;
			updSeen <= updSync;
			extestMeta <= extestTck;
			extestSys <= extestMeta;
			if (updSync != updSeen) updSys <= updReg;
		end
	end

	wire [BSR_LEN-1:0] next_pinOut = extestSys ? updSys : coreOut;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pinOut <= '0;
			pullUpEn <= 1'b1;
		end else begin
			pinOut <= next_pinOut;
			pullUpEn <= 1'b1;
		end
	end

	// ---------------- checks ----------------
	a_ir_reset_bypass: assert property (@(posedge tck) disable iff (rstTck)
		state == bst_pkg::TLR |=> ir == bst_pkg::OP_BYPASS) else $error("ir not bypass after reset");
	a_bypass_one_delay: assert property (@(posedge tck) disable iff (rstTck)
		(inShDr && !bsrSel) |=> bypassReg == $past(tdi)) else $error("bypass delay wrong");
	a_ir_update_load: assert property (@(posedge tck) disable iff (rstTck)
		state == bst_pkg::UP_IR |=> ir == $past(irShift)) else $error("ir update wrong");
	a_bsr_capture_pins: assert property (@(posedge tck) disable iff (rstTck)
		(inCapDr && bsrSel) |=> bsrShift == $past(snapTck)) else $error("capture missed pins");
	a_bsr_shift_in: assert property (@(posedge tck) disable iff (rstTck)
		(inShDr && bsrSel) |=> bsrShift[BSR_LEN-1] == $past(tdi)
			&& bsrShift[0] == $past(bsrShift[1])) else $error("bsr shift wrong");
	a_update_hold: assert property (@(posedge tck) disable iff (rstTck)
		(inUpDr && bsrSel) |=> updReg == $past(bsrShift) && updTog != $past(updTog))
		else $error("update stage not loaded");
	a_tdo_float: assert property (@(posedge tck) disable iff (rstTck)
		!$past(rstTck) |-> tdoOe == (inShIr || inShDr)) else $error("tdo enable wrong");
	a_tms_reset: assert property (@(posedge tck) disable iff (rstTck)
		tms [*5] |=> state == bst_pkg::TLR) else $error("five tms ones did not reset tap");
	a_extest_drive: assert property (@(posedge clk_sys) disable iff (rst)
		extestSys |=> pinOut == $past(updSys)) else $error("extest pins not from update");
	a_core_drive: assert property (@(posedge clk_sys) disable iff (rst)
		!extestSys |=> pinOut == $past(coreOut)) else $error("core path disturbed");
	a_pullup_on: assert property (@(posedge clk_sys) disable iff (rst)
		$past(rst) || !rst |-> pullUpEn) else $error("pull-ups off");

	c_extest_update: cover property (@(posedge tck) disable iff (rstTck) inUpDr && isExtest);
	c_sample_capture: cover property (@(posedge tck) disable iff (rstTck) inCapDr && isSample);
	c_bypass_shift: cover property (@(posedge tck) disable iff (rstTck) inShDr && !bsrSel);
	c_buf_full: cover property (@(posedge clk_sys) disable iff (rst) !bufInReady);
endmodule
`default_nettype wire

//--- verilog/bst_buf.sv
// boundary-scan support package and the small snapshot buffer
// assumes a single clock per buffer instance and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
package bst_pkg;
	localparam int IR_LEN = 3;
	localparam logic [2:0] OP_EXTEST = 3'h0;
	localparam logic [2:0] OP_SAMPLE = 3'h1;
	localparam logic [2:0] OP_BYPASS = 3'h7;
	localparam logic [2:0] IR_CAPT = 3'h1;
	localparam int BSR_LEN_DEF = 273;
	localparam int BUF_DEPTH_DEF = 2;
	localparam int TLR_TMS_ONES = 5;
	typedef enum logic [3:0] {
		TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
		SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
		UP_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
		EX1_IR = 4'hC, PA_IR = 4'hD, EX2_IR = 4'hE, UP_IR = 4'hF
	} bst_tap_state_t;
	typedef struct packed {
		logic data;
		logic oe;
	} bst_tdo_t;
endpackage

module bst_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = bst_pkg::BUF_DEPTH_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	wire doWr = inValid && inReady;
	wire doRd = outValid && outReady;
	wire [AW-1:0] next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
	wire [AW-1:0] next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
	assign inReady = (count != (AW + 1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];

	always_ff @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (doWr) wrPtr <= next_wrPtr;
			if (doRd) rdPtr <= next_rdPtr;
			count <= count + (AW + 1)'(doWr) - (AW + 1)'(doRd);
		end
	end

	a_buf_no_overflow: assert property (@(posedge clk) disable iff (rst)
		count <= (AW + 1)'(DEPTH)) else $error("buffer count above depth");
endmodule
`default_nettype wire

//--- dv/bst_tester.sv
// boundary-scan tester model: makes tck and drives tms and tdi, samples tdo
// assumes the tap samples on rising tck and moves tdo on falling tck
`timescale 1ns/1ps
`default_nettype none
module bst_tester #(
	parameter int N = 273
) (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// tck stands still low between frames; idle lines sit at the pull-up level
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// one 30 ns tck period: set up on the low half, tdo taken at the rising edge
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#15 tck = 1'b1;
		q = tdo;
		#15 tck = 1'b0;
	endtask
	task automatic idle(input int n, input logic m);
		logic q;
		repeat (n) step(m, 1'b1, q);
	endtask
	// starts and ends in run-test-idle
	task automatic scan(input logic ir, input int n, input logic [N-1:0] din,
		output logic [N-1:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the boundary-scan port, 273-cell variant
// assumes the tester model owns tck; pins and core values come from the bench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int N = 273;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [N-1:0] pinIn = '0;
	logic [N-1:0] coreOut = '0;
	logic [N-1:0] dout;
	wire logic tck, tms, tdi, tdo, tdoOe, pullUpEn, tdoLine;
	wire logic [N-1:0] pinOut;
	int miscompares = 0;
	int num_checks = 0;
	always #4 clk_sys = ~clk_sys;
	// a released tdo floats up through its pull-up
	assign tdoLine = tdoOe ? tdo : 1'b1;
	bst_tap #(.BSR_LEN(N)) bst_tap_inst (.clk_sys(clk_sys), .rst(rst), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .pullUpEn(pullUpEn),
		.pinIn(pinIn), .coreOut(coreOut), .pinOut(pinOut));
	bst_tester #(.N(N)) bst_tester_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoLine));
	task automatic check(input logic [N-1:0] seen, input logic [N-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic clks(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic t_reset();
		#1;
		check(pinOut, '0);
		check(pullUpEn, 1'b1);
		check(tdoOe, 1'b0);
	endtask
	// every code but the two test codes must behave as a one-bit bypass
	task automatic t_bypass();
		logic [2:0] op;
		@(posedge clk_sys);
		coreOut <= {91{3'h5}};
		for (int c = 2; c < 8; c++) begin
			op = c[2:0];
			bst_tester_inst.scan(1'b1, 3, N'(op), dout);
			check(dout[2:0], 3'h1);
			bst_tester_inst.scan(1'b0, 8, N'(8'hB5), dout);
			check(dout[7:0], 8'h6A);
			check(pinOut, {91{3'h5}});
		end
	endtask
	task automatic t_sample();
		@(posedge clk_sys);
		pinIn <= {91{3'h6}};
		clks(12);
		bst_tester_inst.scan(1'b1, 3, N'(3'h1), dout);
		// pin snapshots only drain across while tck runs: let the queue catch up first
		bst_tester_inst.idle(20, 1'b0);
		bst_tester_inst.scan(1'b0, N, {91{3'h3}} ^ N'(12'hA5C), dout);
		check(dout, {91{3'h6}});
		clks(6);
		check(pinOut, {91{3'h5}});
	endtask
	// the preloaded pattern must reach the pins once the test mode is entered
	task automatic t_extest();
		@(posedge clk_sys);
		pinIn <= {91{3'h4}} ^ N'(8'h3C);
		bst_tester_inst.scan(1'b1, 3, N'(3'h0), dout);
		bst_tester_inst.idle(4, 1'b0);
		clks(6);
		check(pinOut, {91{3'h3}} ^ N'(12'hA5C));
		bst_tester_inst.idle(20, 1'b0);
		bst_tester_inst.scan(1'b0, N, {91{3'h1}} ^ N'(12'h9F1), dout);
		check(dout, {91{3'h4}} ^ N'(8'h3C));
		bst_tester_inst.idle(4, 1'b0);
		clks(6);
		check(pinOut, {91{3'h1}} ^ N'(12'h9F1));
		bst_tester_inst.idle(5, 1'b1);
		bst_tester_inst.idle(4, 1'b0);
		clks(6);
		check(pinOut, {91{3'h5}});
	endtask
	initial begin
		fork
			clks(10);
			bst_tester_inst.idle(8, 1'b1);
		join
		t_reset();
		@(posedge clk_sys);
		rst <= 1'b0;
		bst_tester_inst.idle(3, 1'b1);
		bst_tester_inst.idle(1, 1'b0);
		t_bypass();
		t_sample();
		t_extest();
		end_of_test();
	end
	// a hang is cut short well inside the cycle budget
	initial begin
		#500000;
		miscompares++;
		end_of_test();
	end
endmodule
`default_nettype wire
